// [pkg/rcf_pkg.sv]
// Constants, field layouts and carriers of the command framer.
// Assumes one clock; all users import the whole package.
package rcf_pkg;

   // Frame bytes
   localparam logic [7:0]  RCF_SOF = 8'h7E;
   localparam logic [7:0]  RCF_TYPE_REQ = 8'h17;
   localparam logic [7:0]  RCF_TYPE_RSP = 8'h88;
   localparam logic [7:0]  RCF_CSUM_FULL = 8'hFF;
   localparam logic [7:0]  RCF_OPT_APPLY = 8'h02;
   localparam logic [15:0] RCF_RSVD_VAL = 16'hFFFE;
   localparam logic [63:0] RCF_BCAST_ADDR = 64'h0000_0000_0000_FFFF;

   // Request offsets within a frame
   localparam logic [15:0] RCF_OFS_TYPE = 16'h0003;
   localparam logic [15:0] RCF_OFS_ID = 16'h0004;
   localparam logic [15:0] RCF_OFS_ADDR = 16'h0005;
   localparam logic [15:0] RCF_OFS_ADDR_END = 16'h000C;
   localparam logic [15:0] RCF_OFS_RSVD = 16'h000D;
   localparam logic [15:0] RCF_OFS_RSVD_END = 16'h000E;
   localparam logic [15:0] RCF_OFS_OPT = 16'h000F;
   localparam logic [15:0] RCF_OFS_CMD = 16'h0010;
   localparam logic [15:0] RCF_OFS_CMD_END = 16'h0011;
   localparam logic [15:0] RCF_OFS_PARAM = 16'h0012;
   localparam logic [15:0] RCF_LEN_TO_LAST = 16'h0002;
   localparam logic [15:0] RCF_REQ_MIN_LEN = 16'h000F;
   localparam logic [15:0] RCF_REQ_MAX_LEN = 16'h0017;
   localparam logic [3:0]  RCF_PARAM_MAX = 4'h8;

   // Response byte positions
   localparam logic [4:0]  RCF_POS_SOF = 5'h00;
   localparam logic [4:0]  RCF_POS_LEN_HI = 5'h01;
   localparam logic [4:0]  RCF_POS_LEN_LO = 5'h02;
   localparam logic [4:0]  RCF_POS_TYPE = 5'h03;
   localparam logic [4:0]  RCF_POS_ID = 5'h04;
   localparam logic [4:0]  RCF_POS_CMD0 = 5'h05;
   localparam logic [4:0]  RCF_POS_CMD1 = 5'h06;
   localparam logic [4:0]  RCF_POS_STATUS = 5'h07;
   localparam logic [4:0]  RCF_POS_DATA = 5'h08;
   localparam logic [15:0] RCF_RSP_BASE_LEN = 16'h0005;

   // Status codes
   localparam logic [7:0]  RCF_ST_OK = 8'h00;
   localparam logic [7:0]  RCF_ST_ERROR = 8'h01;
   localparam logic [7:0]  RCF_ST_BAD_CMD = 8'h02;
   localparam logic [7:0]  RCF_ST_BAD_PARAM = 8'h03;

   // Register byte offsets
   localparam logic [7:0]  RCF_REG_CTRL = 8'h00;
   localparam logic [7:0]  RCF_REG_RSP = 8'h04;
   localparam logic [7:0]  RCF_REG_RSP_D0 = 8'h08;
   localparam logic [7:0]  RCF_REG_RSP_D1 = 8'h0C;
   localparam logic [7:0]  RCF_REG_REQ_INFO = 8'h10;
   localparam logic [7:0]  RCF_REG_ADDR_HI = 8'h14;
   localparam logic [7:0]  RCF_REG_ADDR_LO = 8'h18;
   localparam logic [7:0]  RCF_REG_PARAM0 = 8'h1C;
   localparam logic [7:0]  RCF_REG_PARAM1 = 8'h20;
   localparam logic [7:0]  RCF_REG_MISC = 8'h24;
   localparam logic [7:0]  RCF_REG_IRQ_STAT = 8'h28;
   localparam logic [7:0]  RCF_REG_IRQ_MASK = 8'h2C;
   localparam logic [7:0]  RCF_REG_NONE = 8'hFC;

   // Field positions
   localparam int RCF_CTRL_RX_EN = 0;
   localparam int RCF_CTRL_SEND = 1;
   localparam int RCF_CTRL_RELEASE = 2;
   localparam int RCF_CTRL_HELD = 4;
   localparam int RCF_CTRL_BUSY = 5;
   localparam int RCF_MISC_IS_WR = 4;
   localparam int RCF_MISC_APPLY = 5;
   localparam int RCF_MISC_OPT_BAD = 6;
   localparam int RCF_MISC_RSVD_OK = 7;
   localparam int RCF_MISC_BCAST = 8;
   localparam int RCF_IRQ_REQ = 0;
   localparam int RCF_IRQ_DROP = 1;
   localparam int RCF_IRQ_DONE = 2;

   // Reset values
   localparam logic        RCF_RX_EN_RST = 1'b0;
   localparam logic [2:0]  RCF_MASK_RST = 3'h0;

   typedef struct packed {
      logic [7:0]  id;
      logic [63:0] addr;
      logic [15:0] rsvd;
      logic [7:0]  opt;
      logic [15:0] cmd;
      logic [63:0] param;
      logic [3:0]  plen;
   } rcf_req_t;

   typedef struct packed {
      logic [7:0]  id;
      logic [15:0] cmd;
      logic [7:0]  status;
      logic [3:0]  dlen;
      logic [63:0] data;
   } rcf_rsp_t;

   function automatic logic [7:0] rcf_csum_add(input logic [7:0] sum,
                                               input logic [7:0] b);
      rcf_csum_add = sum + b;
   endfunction

   function automatic logic [7:0] rcf_csum_final(input logic [7:0] sum);
      rcf_csum_final = RCF_CSUM_FULL - sum;
   endfunction

endpackage

// [rtl/rcf_rx_parser.sv]
// Receive side: parses request frames from the host byte stream.
// Assumes same-clock bytes, one per rx_valid_i cycle.
`timescale 1ns/1ps
`default_nettype none
module rcf_rx_parser
   import rcf_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic [7:0] rx_byte_i,
   input  wire logic       rx_valid_i,
   input  wire logic       hold_i,
   output var  rcf_req_t   req_o,
   output var  logic       got_o,
   output var  logic       drop_o
);

   typedef enum logic [2:0] {P_IDLE, P_LEN_HI, P_LEN_LO, P_BODY, P_CSUM}
      rcf_pst_t;

   typedef struct packed {
      rcf_pst_t    st;
      logic [15:0] len;
      logic [15:0] idx;
      logic [7:0]  sum;
      logic [7:0]  ftype;
      rcf_req_t    req;
      logic        got;
      logic        drop;
   } rcf_prs_t;

   localparam rcf_prs_t PRS_RST = '{st: P_IDLE, default: '0};

   rcf_prs_t r;
   rcf_prs_t n;

   always_comb begin
      logic ok;
      ok     = 1'b0;
      n      = r;
      n.got  = 1'b0;
      n.drop = 1'b0;
      if (rx_valid_i) begin
         case (r.st)
            P_IDLE: begin
               if (rx_byte_i == RCF_SOF) begin // [RL1]
                  n.st = P_LEN_HI;
               end
            end
            P_LEN_HI: begin
               n.len[15:8] = rx_byte_i; // [RL1]
               n.st        = P_LEN_LO;
            end
            P_LEN_LO: begin
               n.len[7:0] = rx_byte_i;
               n.idx      = RCF_OFS_TYPE;
               n.sum      = '0;
               n.ftype    = '0;
               n.req      = '0;
               n.st       = ({r.len[15:8], rx_byte_i} == 16'h0000) ?
                            P_CSUM : P_BODY;
            end
            P_BODY: begin
               n.sum = rcf_csum_add(r.sum, rx_byte_i); // [RL8]
               if (r.idx == RCF_OFS_TYPE) begin
                  n.ftype = rx_byte_i;
               end else if (r.idx == RCF_OFS_ID) begin
                  n.req.id = rx_byte_i;
               end else if (r.idx <= RCF_OFS_ADDR_END) begin
                  n.req.addr = {r.req.addr[55:0], rx_byte_i};
               end else if (r.idx <= RCF_OFS_RSVD_END) begin
                  n.req.rsvd = {r.req.rsvd[7:0], rx_byte_i};
               end else if (r.idx == RCF_OFS_OPT) begin
                  n.req.opt = rx_byte_i;
               end else if (r.idx <= RCF_OFS_CMD_END) begin
                  n.req.cmd = {r.req.cmd[7:0], rx_byte_i};
               end else if (r.req.plen < RCF_PARAM_MAX) begin
                  // Write value [RL7]
                  n.req.param[r.req.plen*8 +: 8] = rx_byte_i;
                  n.req.plen = r.req.plen + 4'h1;
               end
               n.idx = r.idx + 16'h0001;
               if (r.idx == r.len + RCF_LEN_TO_LAST) begin
                  n.st = P_CSUM;
               end
            end
            P_CSUM: begin
               // Frames drop while a request is held
               ok = (rx_byte_i == rcf_csum_final(r.sum)) && // [RL8]
                    (r.ftype == RCF_TYPE_REQ) &&
                    (r.len >= RCF_REQ_MIN_LEN) &&
                    (r.len <= RCF_REQ_MAX_LEN) && !hold_i;
               n.got  = ok;
               n.drop = !ok; // [RL15]
               n.st   = P_IDLE;
            end
            default: n.st = P_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         r <= PRS_RST;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign req_o  = r.req;
   assign got_o  = r.got;
   assign drop_o = r.drop;

endmodule
`default_nettype wire

// [rtl/rcf_tx_builder.sv]
// Transmit side: serialises one response frame per start pulse.
// Assumes the sink takes a byte on a cycle with tx_valid_o and tx_ready_i.
`timescale 1ns/1ps
`default_nettype none
module rcf_tx_builder
   import rcf_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       start_i,
   input  wire rcf_rsp_t   rsp_i,
   input  wire logic       tx_ready_i,
   output var  logic [7:0] tx_byte_o,
   output var  logic       tx_valid_o,
   output var  logic       busy_o,
   output var  logic       done_o
);

   typedef enum logic {B_IDLE, B_SEND} rcf_bst_t;

   typedef struct packed {
      rcf_bst_t   st;
      logic [4:0] pos;
      logic [4:0] last;
      logic [7:0] sum;
      rcf_rsp_t   rsp;
      logic [7:0] data;
      logic       valid;
      logic       done;
   } rcf_bld_t;

   localparam rcf_bld_t BLD_RST = '{st: B_IDLE, default: '0};

   rcf_bld_t r;
   rcf_bld_t n;

   function automatic logic [7:0] byte_at(input logic [4:0] pos,
                                          input rcf_rsp_t   rsp,
                                          input logic [7:0] sum);
      logic [15:0] len;
      logic [4:0]  di;
      len = RCF_RSP_BASE_LEN + {12'h000, rsp.dlen};
      di  = pos - RCF_POS_DATA;
      case (pos)
         RCF_POS_SOF:    byte_at = RCF_SOF; // [RL1]
         RCF_POS_LEN_HI: byte_at = len[15:8];
         RCF_POS_LEN_LO: byte_at = len[7:0];
         RCF_POS_TYPE:   byte_at = RCF_TYPE_RSP; // [RL9]
         RCF_POS_ID:     byte_at = rsp.id; // [RL11]
         RCF_POS_CMD0:   byte_at = rsp.cmd[15:8]; // [RL12]
         RCF_POS_CMD1:   byte_at = rsp.cmd[7:0];
         RCF_POS_STATUS: byte_at = rsp.status; // [RL13]
         default: begin
            if (di < {1'b0, rsp.dlen}) begin
               byte_at = rsp.data[di[2:0]*8 +: 8]; // [RL14]
            end else begin
               byte_at = rcf_csum_final(sum); // [RL8]
            end
         end
      endcase
   endfunction

   always_comb begin
      logic [7:0] nsum;
      nsum   = r.sum;
      n      = r;
      n.done = 1'b0;
      case (r.st)
         B_IDLE: begin
            if (start_i) begin
               n.rsp   = rsp_i;
               n.pos   = RCF_POS_SOF;
               n.last  = RCF_POS_DATA + {1'b0, rsp_i.dlen};
               n.sum   = '0;
               n.data  = RCF_SOF;
               n.valid = 1'b1;
               n.st    = B_SEND;
            end
         end
         B_SEND: begin
            if (tx_ready_i) begin
               if (r.pos == r.last) begin
                  n.valid = 1'b0;
                  n.done  = 1'b1;
                  n.st    = B_IDLE;
               end else begin
                  if (r.pos >= RCF_POS_TYPE) begin
                     nsum = rcf_csum_add(r.sum, r.data); // [RL8]
                  end
                  n.sum  = nsum;
                  n.pos  = r.pos + 5'h01;
                  n.data = byte_at(n.pos, r.rsp, nsum);
               end
            end
         end
         default: n.st = B_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         r <= BLD_RST;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign tx_byte_o  = r.data;
   assign tx_valid_o = r.valid;
   assign busy_o     = (r.st != B_IDLE);
   assign done_o     = r.done;

endmodule
`default_nettype wire

// [rtl/rcf_top.sv]
// Remote command framer: parser, builder and AHB-Lite registers.
// Assumes one clock; byte streams come from same-clock logic.
//
// How it works
// (RL1) Frames open with 0x7E, then a big-endian length of the body.
// (RL2) Host sends requests with type 0x17 at offset 3.
// (RL3) A request whose ID at offset 4 is zero gets no response.
// (RL4) Host puts the 64-bit target at offsets 5-12, then 0xFFFE.
// (RL5) Option 0x02 applies at once; other option bits must be zero.
// (RL6) Host puts the two-character name at offsets 16 and 17.
// (RL7) Bytes from offset 18 are a value to write; none means a read.
// (RL8) Checksum is 0xFF minus the byte sum from offset 3 onward.
// (RL9) Every response is a frame of type 0x88.
// (RL10) One request may be answered by several response frames.
// (RL11) Response carries the request ID at offset 4; zero ID, no reply.
// (RL12) Response repeats the two name characters at offsets 5 and 6.
// (RL13) Status at offset 7: 0 OK, 1 error, 2 bad command, 3 bad value.
// (RL14) Read data follows the status; omitted when the request wrote.
// (RL15) Frames with bad checksum or impossible length are dropped.
`timescale 1ns/1ps
`default_nettype none
module rcf_top
   import rcf_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output var  logic [31:0] hrdata_o,
   output var  logic        hreadyout_o,
   output var  logic        hresp_o,
   input  wire logic [7:0]  rx_byte_i,
   input  wire logic        rx_valid_i,
   output var  logic [7:0]  tx_byte_o,
   output var  logic        tx_valid_o,
   input  wire logic        tx_ready_i,
   output var  logic        irq_o
);

   typedef struct packed {
      logic        ap_valid;
      logic        ap_wr;
      logic [7:0]  ap_ofs;
      logic [31:0] hrdata;
      logic        hready;
      logic        hresp;
      logic        rx_en;
      logic        req_held;
      rcf_req_t    req;
      logic [7:0]  rsp_status;
      logic [3:0]  rsp_dlen;
      logic [63:0] rsp_data;
      logic        start;
      logic [2:0]  stat;
      logic [2:0]  mask;
      logic        irq;
   } rcf_top_t;

   localparam rcf_top_t TOP_RST = '{
      hready:     1'b1,
      rx_en:      RCF_RX_EN_RST,
      rsp_status: RCF_ST_OK,
      mask:       RCF_MASK_RST,
      default:    '0
   };

   rcf_top_t r;
   rcf_top_t n;

   rcf_req_t p_req;
   logic     p_got;
   logic     p_drop;
   rcf_rsp_t rsp;
   logic     tx_busy;
   logic     tx_done;

   rcf_rx_parser u_parser (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .ce_i       (ce_i),
      .rx_byte_i  (rx_byte_i),
      .rx_valid_i (rx_valid_i & r.rx_en),
      .hold_i     (r.req_held),
      .req_o      (p_req),
      .got_o      (p_got),
      .drop_o     (p_drop)
   );

   // Held request plus software's answer
   always_comb begin
      rsp.id     = r.req.id; // [RL11]
      rsp.cmd    = r.req.cmd; // [RL12]
      rsp.status = r.rsp_status; // [RL13]
      rsp.dlen   = (r.req.plen != 4'h0) ? 4'h0 : r.rsp_dlen; // [RL14]
      rsp.data   = r.rsp_data;
   end

   rcf_tx_builder u_builder (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .ce_i       (ce_i),
      .start_i    (r.start),
      .rsp_i      (rsp),
      .tx_ready_i (tx_ready_i),
      .tx_byte_o  (tx_byte_o),
      .tx_valid_o (tx_valid_o),
      .busy_o     (tx_busy),
      .done_o     (tx_done)
   );

   always_comb begin
      logic        ap;
      logic [7:0]  ofs;
      logic [31:0] rd;
      logic [31:0] wd;
      logic [2:0]  clr;
      logic [2:0]  set;
      logic        send_ok;
      n       = r;
      n.start = 1'b0;
      n.hready = 1'b1;
      n.hresp  = 1'b0;
      ap      = hsel_i && hready_i && htrans_i[1];
      ofs     = (haddr_i[31:8] == 24'h000000) ? haddr_i[7:0] : RCF_REG_NONE;
      rd      = '0;
      wd      = hwdata_i;
      clr     = 3'h0;
      set     = 3'h0;
      // Held request may be answered many times
      send_ok = r.req_held && (r.req.id != 8'h00) && // [RL3] [RL10]
                !tx_busy && !r.start;

      // Zero wait states
      case (ofs)
         RCF_REG_CTRL: begin
            rd[RCF_CTRL_RX_EN] = r.rx_en;
            rd[RCF_CTRL_HELD]  = r.req_held;
            rd[RCF_CTRL_BUSY]  = tx_busy;
         end
         RCF_REG_RSP: begin
            rd[7:0]  = r.rsp_status;
            rd[11:8] = r.rsp_dlen;
         end
         RCF_REG_RSP_D0:   rd = r.rsp_data[31:0];
         RCF_REG_RSP_D1:   rd = r.rsp_data[63:32];
         RCF_REG_REQ_INFO: rd = {r.req.cmd, r.req.opt, r.req.id};
         RCF_REG_ADDR_HI:  rd = r.req.addr[63:32];
         RCF_REG_ADDR_LO:  rd = r.req.addr[31:0];
         RCF_REG_PARAM0:   rd = r.req.param[31:0];
         RCF_REG_PARAM1:   rd = r.req.param[63:32];
         RCF_REG_MISC: begin
            rd[3:0]              = r.req.plen;
            rd[RCF_MISC_IS_WR]   = (r.req.plen != 4'h0); // [RL7]
            rd[RCF_MISC_APPLY]   = |(r.req.opt & RCF_OPT_APPLY); // [RL5]
            rd[RCF_MISC_OPT_BAD] = |(r.req.opt & ~RCF_OPT_APPLY); // [RL5]
            rd[RCF_MISC_RSVD_OK] = (r.req.rsvd == RCF_RSVD_VAL);
            rd[RCF_MISC_BCAST]   = (r.req.addr == RCF_BCAST_ADDR);
         end
         RCF_REG_IRQ_STAT: rd[2:0] = r.stat;
         RCF_REG_IRQ_MASK: rd[2:0] = r.mask;
         default:          rd = '0;
      endcase

      n.ap_valid = ap;
      n.ap_wr    = hwrite_i;
      n.ap_ofs   = ofs;
      if (ap && !hwrite_i) begin
         n.hrdata = rd;
         if (ofs == RCF_REG_IRQ_STAT) begin
            clr = 3'h7;
         end
      end

      // Write data comes one cycle after its address
      if (r.ap_valid && r.ap_wr) begin
         case (r.ap_ofs)
            RCF_REG_CTRL: begin
               n.rx_en = wd[RCF_CTRL_RX_EN];
               if (wd[RCF_CTRL_SEND] && send_ok) begin
                  n.start = 1'b1; // [RL9] [RL11]
               end
               if (wd[RCF_CTRL_RELEASE]) begin
                  n.req_held = 1'b0;
               end
            end
            RCF_REG_RSP: begin
               n.rsp_status = wd[7:0]; // [RL13]
               n.rsp_dlen   = (wd[11:8] > RCF_PARAM_MAX) ?
                              RCF_PARAM_MAX : wd[11:8];
            end
            RCF_REG_RSP_D0:   n.rsp_data[31:0]  = wd;
            RCF_REG_RSP_D1:   n.rsp_data[63:32] = wd;
            RCF_REG_IRQ_MASK: n.mask = wd[2:0];
            default: ;
         endcase
      end

      // Parser drops frames while held: no clash with release
      if (p_got) begin
         n.req      = p_req; // [RL7]
         n.req_held = 1'b1;
      end

      set[RCF_IRQ_REQ]  = p_got;
      set[RCF_IRQ_DROP] = p_drop; // [RL15]
      set[RCF_IRQ_DONE] = tx_done;
      // Set beats read-clear
      n.stat = (r.stat & ~clr) | set;
      n.irq  = |(n.stat & n.mask);
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         r <= TOP_RST;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign hrdata_o    = r.hrdata;
   assign hreadyout_o = r.hready;
   assign hresp_o     = r.hresp;
   assign irq_o       = r.irq;

endmodule
`default_nettype wire

// [sim/rcf_checker.sv]
// Checker: response framing and bus answers of rcf_top.
// Assumes a bind to rcf_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rcf_checker
   import rcf_pkg::*;
(
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic       hreadyout_o,
   input wire logic       hresp_o,
   input wire logic [7:0] tx_byte_o,
   input wire logic       tx_valid_o,
   input wire logic       tx_ready_i,
   input wire logic       irq_o
);
   logic [7:0] idx_r;
   logic [7:0] len_r;
   logic [7:0] sum_r;
   logic       take;
   assign take = tx_valid_o && tx_ready_i;
   // Index restarts between frames
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !tx_valid_o) begin
         idx_r <= 8'h00;
         sum_r <= 8'h00;
      end else if (take) begin
         idx_r <= idx_r + 8'h01;
         sum_r <= (idx_r >= 8'h03) ? sum_r + tx_byte_o : sum_r;
         if (idx_r == 8'h02) len_r <= tx_byte_o;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   a_sof_first: assert property (
      tx_valid_o && idx_r == 8'h00 |-> tx_byte_o == RCF_SOF)
      else $error("no start byte");
   a_len_hi: assert property (
      tx_valid_o && idx_r == 8'h01 |-> tx_byte_o == 8'h00)
      else $error("length high not zero");
   a_len_range: assert property (
      tx_valid_o && idx_r == 8'h02 |-> tx_byte_o inside {[8'h05:8'h0D]})
      else $error("bad length");
   a_type_rsp: assert property (
      tx_valid_o && idx_r == 8'h03 |-> tx_byte_o == RCF_TYPE_RSP)
      else $error("bad type");
   a_id_nonzero: assert property (
      tx_valid_o && idx_r == 8'h04 |-> tx_byte_o != 8'h00)
      else $error("zero id sent");
   a_csum_byte: assert property (
      take && idx_r == len_r + 8'h03 |-> tx_byte_o == 8'hFF - sum_r)
      else $error("bad checksum");
   a_tx_hold: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
      else $error("byte not held");
   a_zero_wait: assert property (
      hsel_i && htrans_i[1] |=> hreadyout_o [*2])
      else $error("wait state");
   a_resp_okay: assert property (hreadyout_o |-> !hresp_o)
      else $error("not okay");
   cover property (take && idx_r == 8'h08 && len_r > 8'h05);
   cover property (tx_valid_o && !tx_ready_i);
   cover property ($rose(irq_o));
endmodule
bind rcf_top rcf_checker u_rcf_checker (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
   .hsel_i(hsel_i), .htrans_i(htrans_i), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .irq_o(irq_o));
`default_nettype wire

// [sim/rcf_host_model.sv]
// Host processor model: sends request frames, drains response bytes.
// Assumes the framer's clock; slow_i drops tx_ready_o every other cycle.
`timescale 1ns/1ps
`default_nettype none
module rcf_host_model
   import rcf_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       slow_i,
   output var  logic [7:0] rx_byte_o,
   output var  logic       rx_valid_o,
   output var  logic       tx_ready_o
);
   initial {rx_byte_o, rx_valid_o, tx_ready_o} = 10'h001;
   always @(posedge mclk_i) begin
      tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
   end
   // Set bad to spoil the checksum
   task automatic send_req(input logic [7:0] id, input logic [63:0] addr,
      input logic [7:0] opt, input logic [15:0] cmd,
      input logic [63:0] prm, input int n, input logic bad);
      logic [7:0] f[$];
      logic [7:0] s;
      f = {RCF_SOF, 8'h00, 8'(15 + n), RCF_TYPE_REQ, id};
      for (int i = 7; i >= 0; i--) f.push_back(addr[8*i+:8]);
      f.push_back(RCF_RSVD_VAL[15:8]);
      f.push_back(RCF_RSVD_VAL[7:0]);
      f.push_back(opt);
      f.push_back(cmd[15:8]);
      f.push_back(cmd[7:0]);
      for (int i = 0; i < n; i++) f.push_back(prm[8*i+:8]);
      s = 8'h00;
      for (int i = 3; i < f.size(); i++) s += f[i];
      f.push_back((8'hFF - s) ^ {7'h00, bad});
      foreach (f[i]) begin
         @(posedge mclk_i);
         rx_byte_o <= f[i];
         rx_valid_o <= 1'b1;
      end
      @(posedge mclk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~f[f.size()-1];
   endtask
endmodule
`default_nettype wire

// [sim/test_remote_at_command_framer.sv]
// Bench for rcf_top: AHB-Lite registers, host model on the link.
// Assumes a 50 MHz clock and the register map of rcf_pkg.
`timescale 1ns/1ps
`default_nettype none
module test_remote_at_command_framer
   import rcf_pkg::*;
;
   logic        mclk_i, rst_n_i, hsel, hwrite, rd_dp, slow;
   logic        hreadyout, hresp, tx_valid, tx_ready, rx_valid, irq;
   logic [1:0]  htrans;
   logic [7:0]  tx_byte, rx_byte;
   logic [31:0] haddr, hwdata, hrdata, lfsr;
   logic [7:0]  exp_tx[$];
   logic [31:0] exp_rd[$];
   int          failures, samples_checked;
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   rcf_top u_rcf_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .tx_byte_o(tx_byte),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .irq_o(irq));
   rcf_host_model u_rcf_host_model (.mclk_i(mclk_i), .slow_i(slow),
      .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .tx_ready_o(tx_ready));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH hrdata exp %h got %h", e, g);
      end
   endtask
   task automatic cmp_tx(input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH tx_byte exp %h got %h", e, g);
      end
   endtask
   // Reads queue their word; the monitor checks it
   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk_i);
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge mclk_i); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h0;
      rd_dp <= ~w;
      if (!w) exp_rd.push_back(d);
      do @(posedge mclk_i); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask
   task automatic exp_rsp(input logic [7:0] id, input logic [15:0] cmd,
      input logic [7:0] st, input int n, input logic [63:0] d);
      logic [7:0] f[$];
      logic [7:0] s;
      f = {RCF_SOF, 8'h00, 8'(5 + n), RCF_TYPE_RSP, id, cmd[15:8], cmd[7:0]};
      f.push_back(st);
      for (int i = 0; i < n; i++) f.push_back(d[8*i+:8]);
      s = 8'h00;
      for (int i = 3; i < f.size(); i++) s += f[i];
      f.push_back(8'hFF - s);
      exp_tx = {exp_tx, f};
   endtask
   task automatic wait_irq();
      for (int i = 0; i < 500 && irq !== 1'b1; i++) @(posedge mclk_i);
   endtask
   task automatic finish_test();
      if (failures == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // A byte with no note fails against its inverse
   always @(posedge mclk_i) begin
      if (rd_dp && hreadyout === 1'b1) cmp_rd(exp_rd.pop_front(), hrdata);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         cmp_tx(exp_tx.size() ? exp_tx.pop_front() : ~tx_byte, tx_byte);
      end
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      failures++;
      finish_test();
   end
   initial begin
      {hsel, hwrite, rd_dp, slow, rst_n_i} = 5'h10;
      {htrans, haddr, hwdata} = '0;
      {failures, samples_checked} = '0;
      lfsr = nxt(32'hFF43);
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      ahb(0, RCF_REG_CTRL, 32'h0);
      ahb(0, RCF_REG_IRQ_MASK, 32'h0);
      ahb(0, RCF_REG_NONE, 32'h0);
      ahb(1, RCF_REG_IRQ_MASK, 32'h7);
      ahb(1, RCF_REG_CTRL, 32'h1);
      u_rcf_host_model.send_req(8'h5A, {lfsr, ~lfsr}, RCF_OPT_APPLY,
         16'h4248, {56'h0, lfsr[7:0]}, 1, 1'b0);
      wait_irq();
      ahb(0, RCF_REG_IRQ_STAT, 32'h1);
      ahb(0, RCF_REG_REQ_INFO, 32'h4248025A);
      ahb(0, RCF_REG_ADDR_HI, lfsr);
      ahb(0, RCF_REG_ADDR_LO, ~lfsr);
      ahb(0, RCF_REG_MISC, 32'hB1);
      ahb(0, RCF_REG_PARAM0, {24'h0, lfsr[7:0]});
      // Write request: no data; odd passes stall
      for (int s = 0; s < 4; s++) begin
         slow <= s[0];
         ahb(1, RCF_REG_RSP, {20'h0, 4'h8, 8'(s)});
         exp_rsp(8'h5A, 16'h4248, 8'(s), 0, 64'h0);
         ahb(1, RCF_REG_CTRL, 32'h3);
         wait_irq();
         ahb(0, RCF_REG_IRQ_STAT, 32'h4);
      end
      ahb(1, RCF_REG_CTRL, 32'h5);
      u_rcf_host_model.send_req(8'h33, RCF_BCAST_ADDR, 8'h00, 16'h4448,
         64'h0, 0, 1'b0);
      wait_irq();
      ahb(0, RCF_REG_IRQ_STAT, 32'h1);
      ahb(0, RCF_REG_MISC, 32'h180);
      lfsr = nxt(lfsr);
      ahb(1, RCF_REG_RSP_D0, lfsr);
      ahb(1, RCF_REG_RSP, 32'h300);
      exp_rsp(8'h33, 16'h4448, 8'h00, 3, {32'h0, lfsr});
      ahb(1, RCF_REG_CTRL, 32'h3);
      wait_irq();
      ahb(0, RCF_REG_IRQ_STAT, 32'h4);
      ahb(1, RCF_REG_CTRL, 32'h5);
      u_rcf_host_model.send_req(8'h00, {lfsr, lfsr}, 8'h00, 16'h4448,
         64'h0, 0, 1'b0);
      wait_irq();
      ahb(0, RCF_REG_IRQ_STAT, 32'h1);
      ahb(1, RCF_REG_CTRL, 32'h3);
      repeat (40) @(posedge mclk_i);
      ahb(0, RCF_REG_IRQ_STAT, 32'h0);
      ahb(1, RCF_REG_CTRL, 32'h5);
      u_rcf_host_model.send_req(8'h21, {lfsr, lfsr}, 8'h00, 16'h4448,
         64'h0, 0, 1'b1);
      wait_irq();
      ahb(0, RCF_REG_IRQ_STAT, 32'h2);
      ahb(0, RCF_REG_CTRL, 32'h1);
      @(posedge mclk_i);
      finish_test();
   end
endmodule
`default_nettype wire
